// ==== core/cbc_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cbc_defs.svh"
module cbc_core (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // instruction issue
  input  wire logic                 start_i,
  input  wire logic [7:0]           opcode_i,
  // memory read data, valid the state after a read request
  input  wire logic [7:0]           mem_rdata_i,
  // flags in from the rest of the processor
  input  wire cbc_pkg::cbc_flags_t  flags_i,
  // memory request
  output cbc_pkg::cbc_mem_req_t     mem_o,
  // architectural state
  output logic [15:0]               pc_o,
  output logic [15:0]               sp_o,
  output cbc_pkg::cbc_flags_t       flags_o,
  output logic                      taken_o,
  output logic                      busy_o,
  output logic                      done_o
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    CBC_ST_IDLE = 3'h0,
    CBC_ST_RD1  = 3'h1,
    CBC_ST_RD2  = 3'h2,
    CBC_ST_WR1  = 3'h3,
    CBC_ST_WR2  = 3'h4,
    CBC_ST_PAD  = 3'h5
  } cbc_state_t;

  function automatic logic cond_true(input logic [2:0] sel,
                                     input cbc_pkg::cbc_flags_t f);
    logic v;
    v = 1'b0;
    unique case (sel[2:1])
      2'h0: v = f.zero;
      2'h1: v = f.carry;
      2'h2: v = f.parity;
      2'h3: v = f.sign;
    endcase
    cond_true = sel[0] ? v : ~v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  cbc_pkg::cbc_decode_t  dec;
  cbc_decoder u_dec (
    .opcode_i (opcode_i),
    .dec_o    (dec)
  );

  cbc_state_t            st_q,    st_d;
  cbc_pkg::cbc_op_t      op_q,    op_d;
  logic [15:0]           pc_q,    pc_d;
  logic [15:0]           sp_q,    sp_d;
  logic [15:0]           tgt_q,   tgt_d;
  logic [7:0]            lo_q,    lo_d;
  logic [3:0]            cnt_q,   cnt_d;
  logic                  go_q,    go_d;
  logic                  done_q,  done_d;
  logic                  busy_q,  busy_d;
  cbc_pkg::cbc_flags_t   fl_q,    fl_d;
  cbc_pkg::cbc_mem_req_t mem_q,   mem_d;
  logic [15:0]           pc_next;
  logic                  cond_ok;

  assign pc_next = pc_q + 16'h0001;
  assign cond_ok = ~dec.conditional | cond_true(dec.field, flags_i);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d   = st_q;
    op_d   = op_q;
    pc_d   = pc_q;
    sp_d   = sp_q;
    tgt_d  = tgt_q;
    lo_d   = lo_q;
    cnt_d  = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
    go_d   = go_q;
    done_d = 1'b0;
    fl_d   = fl_q;
    mem_d  = '0;
    unique case (st_q)
      CBC_ST_IDLE: begin
        fl_d = flags_i;
        if (start_i) begin
          op_d = dec.op;
          go_d = cond_ok;
          unique case (dec.op)
            cbc_pkg::CBC_OP_CARRY: begin
              fl_d.carry = dec.invert ? ~flags_i.carry : 1'b1;
              pc_d  = pc_next;
              cnt_d = 4'(`CBC_STATES_CARRY - 2);
              st_d  = CBC_ST_PAD;
            end
            cbc_pkg::CBC_OP_BRANCH, cbc_pkg::CBC_OP_CALL: begin
              pc_d       = pc_next;
              mem_d.rd   = 1'b1;
              mem_d.addr = pc_next;
              st_d       = CBC_ST_RD1;
            end
            cbc_pkg::CBC_OP_EXIT: begin
              pc_d = pc_next;
              if (cond_ok) begin
                mem_d.rd   = 1'b1;
                mem_d.addr = sp_q;
                st_d       = CBC_ST_RD1;
              end else begin
                cnt_d = 4'h3;
                st_d  = CBC_ST_PAD;
              end
            end
            cbc_pkg::CBC_OP_RESTART: begin
              tgt_d = {10'h000, dec.field, 3'h0};
              pc_d  = pc_next;
              sp_d  = sp_q - 16'h0001;
              mem_d.wr    = 1'b1;
              mem_d.addr  = sp_q - 16'h0001;
              mem_d.wdata = pc_next[15:8];
              st_d  = CBC_ST_WR1;
            end
            default: begin
              pc_d   = pc_next;
              done_d = 1'b1;
            end
          endcase
        end
      end
      CBC_ST_RD1: begin
        lo_d = mem_rdata_i;
        if (op_q == cbc_pkg::CBC_OP_EXIT) begin
          mem_d.addr = sp_q + 16'h0001;
        end else begin
          pc_d       = pc_q + 16'h0001;
          mem_d.addr = pc_q + 16'h0001;
        end
        mem_d.rd = 1'b1;
        st_d     = CBC_ST_RD2;
      end
      CBC_ST_RD2: begin
        tgt_d = {mem_rdata_i, lo_q};
        if (op_q == cbc_pkg::CBC_OP_EXIT) begin
          pc_d = {mem_rdata_i, lo_q};
          sp_d = sp_q + 16'h0002;
          cnt_d = 4'(`CBC_STATES_EXIT - 6);
          st_d  = CBC_ST_PAD;
        end else if (go_q && op_q == cbc_pkg::CBC_OP_CALL) begin
          pc_d        = pc_q + 16'h0001;
          sp_d        = sp_q - 16'h0001;
          mem_d.wr    = 1'b1;
          mem_d.addr  = sp_q - 16'h0001;
          mem_d.wdata = pc_next[15:8];
          st_d        = CBC_ST_WR1;
        end else begin
          pc_d  = go_q ? {mem_rdata_i, lo_q} : pc_q + 16'h0001;
          cnt_d = 4'(`CBC_STATES_BRANCH - 6);
          st_d  = CBC_ST_PAD;
        end
      end
      CBC_ST_WR1: begin
        sp_d        = sp_q - 16'h0001;
        mem_d.wr    = 1'b1;
        mem_d.addr  = sp_q - 16'h0001;
        mem_d.wdata = pc_q[7:0];
        st_d        = CBC_ST_WR2;
      end
      CBC_ST_WR2: begin
        pc_d  = tgt_q;
        cnt_d = 4'(`CBC_STATES_RESTART - 8);
        st_d  = CBC_ST_PAD;
      end
      CBC_ST_PAD: begin
        if (cnt_q == 4'h0) begin
          done_d = 1'b1;
          st_d   = CBC_ST_IDLE;
        end
      end
      default: st_d = CBC_ST_IDLE;
    endcase
    busy_d = (st_d != CBC_ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= CBC_ST_IDLE;
      op_q   <= cbc_pkg::CBC_OP_NONE;
      pc_q   <= `CBC_PC_RESET;
      sp_q   <= `CBC_SP_RESET;
      tgt_q  <= 16'h0000;
      lo_q   <= 8'h00;
      cnt_q  <= 4'h0;
      go_q   <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      fl_q   <= '0;
      mem_q  <= '0;
    end else begin
      st_q   <= st_d;
      op_q   <= op_d;
      pc_q   <= pc_d;
      sp_q   <= sp_d;
      tgt_q  <= tgt_d;
      lo_q   <= lo_d;
      cnt_q  <= cnt_d;
      go_q   <= go_d;
      done_q <= done_d;
      busy_q <= busy_d;
      fl_q   <= fl_d;
      mem_q  <= mem_d;
    end
  end

  assign mem_o   = mem_q;
  assign pc_o    = pc_q;
  assign sp_o    = sp_q;
  assign flags_o = fl_q;
  assign taken_o = go_q;
  assign busy_o  = busy_q;
  assign done_o  = done_q;
endmodule
`default_nettype wire

// ==== core/cbc_decoder.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cbc_defs.svh"
module cbc_decoder (
  // opcode in
  input  wire logic [7:0]          opcode_i,
  // decoded op out
  output cbc_pkg::cbc_decode_t     dec_o
);
  always_comb begin
    dec_o.op          = cbc_pkg::CBC_OP_NONE;
    dec_o.conditional = 1'b0;
    dec_o.field       = opcode_i[`CBC_FIELD_HI:`CBC_FIELD_LO];
    dec_o.invert      = 1'b0;
    if (opcode_i == `CBC_OP_CARRY_INVERT) begin
      dec_o.op     = cbc_pkg::CBC_OP_CARRY;
      dec_o.invert = 1'b1;
    end else if (opcode_i == `CBC_OP_CARRY_FORCE) begin
      dec_o.op = cbc_pkg::CBC_OP_CARRY;
    end else if (opcode_i == `CBC_OP_BRANCH_ALWAYS) begin
      dec_o.op = cbc_pkg::CBC_OP_BRANCH;
    end else if (opcode_i == `CBC_OP_EXIT_ALWAYS) begin
      dec_o.op = cbc_pkg::CBC_OP_EXIT;
    end else if (opcode_i == `CBC_OP_CALL_ALWAYS) begin
      dec_o.op = cbc_pkg::CBC_OP_CALL;
    end else if (opcode_i[7:6] == `CBC_TOP_GROUP) begin
      unique case (opcode_i[2:0])
        `CBC_LOW_BRANCH_COND: begin
          dec_o.op          = cbc_pkg::CBC_OP_BRANCH;
          dec_o.conditional = 1'b1;
        end
        `CBC_LOW_CALL_COND: begin
          dec_o.op          = cbc_pkg::CBC_OP_CALL;
          dec_o.conditional = 1'b1;
        end
        `CBC_LOW_EXIT_COND: begin
          dec_o.op          = cbc_pkg::CBC_OP_EXIT;
          dec_o.conditional = 1'b1;
        end
        `CBC_LOW_RESTART: begin
          dec_o.op = cbc_pkg::CBC_OP_RESTART;
        end
        default: begin
          dec_o.op = cbc_pkg::CBC_OP_NONE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== core/cbc_defs.svh ====
`ifndef CBC_DEFS_SVH
`define CBC_DEFS_SVH
// opcode patterns
`define CBC_OP_CARRY_INVERT    8'h3F
`define CBC_OP_CARRY_FORCE     8'h37
`define CBC_OP_BRANCH_ALWAYS   8'hC3
`define CBC_OP_EXIT_ALWAYS     8'hC9
`define CBC_OP_CALL_ALWAYS     8'hCD
// low three bits of the conditional and restart groups, then their shared top two bits
`define CBC_LOW_BRANCH_COND    3'h2
`define CBC_LOW_CALL_COND      3'h4
`define CBC_LOW_EXIT_COND      3'h0
`define CBC_LOW_RESTART        3'h7
`define CBC_TOP_GROUP          2'h3
// field positions
`define CBC_FIELD_HI           5
`define CBC_FIELD_LO           3
// reset values
`define CBC_PC_RESET           16'h0000
`define CBC_SP_RESET           16'h0000
// timing in processor states
`define CBC_STATES_CARRY       4
`define CBC_STATES_BRANCH      10
`define CBC_STATES_EXIT        10
`define CBC_STATES_RESTART     11
`endif

// ==== core/cbc_pkg.sv ====
package cbc_pkg;
  typedef enum logic [2:0] {
    CBC_OP_NONE    = 3'h0,
    CBC_OP_CARRY   = 3'h1,
    CBC_OP_BRANCH  = 3'h2,
    CBC_OP_EXIT    = 3'h3,
    CBC_OP_CALL    = 3'h4,
    CBC_OP_RESTART = 3'h5
  } cbc_op_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic half_carry;
    logic parity;
    logic carry;
  } cbc_flags_t;

  typedef struct packed {
    cbc_op_t    op;
    logic       conditional;
    logic [2:0] field;
    logic       invert;
  } cbc_decode_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cbc_mem_req_t;
endpackage

// ==== tb/carry_and_branch_control_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module carry_and_branch_control_tb_top;
  logic                  sys_clk_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  logic                  start_i = 1'b0;
  logic [7:0]            opcode_i = 8'h00;
  logic [7:0]            mem_rdata_i;
  cbc_pkg::cbc_flags_t   flags_i = '0;
  cbc_pkg::cbc_mem_req_t mem_o;
  cbc_pkg::cbc_flags_t   flags_o;
  logic [15:0]           pc_o;
  logic [15:0]           sp_o;
  logic                  taken_o;
  logic                  busy_o;
  logic                  done_o;
  int                    num_errors = 0;
  int                    checks = 0;
  int                    cyc = 0;
  integer                seed = 32'h0997dacb;
  logic [15:0]           epc = 16'h0000;
  logic [15:0]           esp = 16'h0000;
  always #20 sys_clk_i = ~sys_clk_i;
  cbc_core i_dut (.sys_clk_i, .rst_n_i, .start_i, .opcode_i, .mem_rdata_i,
    .flags_i, .mem_o, .pc_o, .sp_o, .flags_o, .taken_o, .busy_o, .done_o);
  cbc_mem_model i_mem (.clk_i(sys_clk_i), .req_i(mem_o), .rdata_o(mem_rdata_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (e !== g) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic cnd(logic [2:0] c, cbc_pkg::cbc_flags_t f);
    logic v;
    case (c[2:1])
      2'h0: v = f.zero;
      2'h1: v = f.carry;
      2'h2: v = f.parity;
      default: v = f.sign;
    endcase
    return c[0] ? v : !v;
  endfunction
  task automatic run(logic [7:0] op, cbc_pkg::cbc_flags_t f);
    int n;
    @(posedge sys_clk_i);
    start_i <= 1'b1;
    opcode_i <= op;
    flags_i <= f;
    @(posedge sys_clk_i);
    start_i <= 1'b0;
    n = 0;
    #1;
    while (done_o !== 1'b1 && n < 40) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    cmp("done", 16'h1, 16'(done_o));
    cmp("busy", 16'h0, 16'(busy_o));
  endtask
  // kinds: 0 invert, 1 force, 2 branch, 3 call, 4 exit, 5 restart,
  // 6 exit always, 7 branch always, 8 call always
  task automatic step(int k, int v);
    cbc_pkg::cbc_flags_t f;
    logic [7:0]          op;
    logic [15:0]         a;
    logic [15:0]         nx;
    logic                t;
    f = 5'($random(seed));
    a = 16'($random(seed));
    op = {2'h3, 3'($random(seed)), 3'h0};
    if (v >= 0) op[5:3] = 3'(v);
    case (k)
      0: op = 8'h3F;
      1: op = 8'h37;
      2: op[2:0] = 3'h2;
      3: op[2:0] = 3'h4;
      5: op[2:0] = 3'h7;
      6: op = 8'hC9;
      7: op = 8'hC3;
      8: op = 8'hCD;
      default: op[2:0] = 3'h0;
    endcase
    t = (k < 2 || k > 4) ? 1'b1 : cnd(op[5:3], f);
    i_mem.m[epc + 16'h1] = a[7:0];
    i_mem.m[epc + 16'h2] = a[15:8];
    nx = epc + ((k == 2 || k == 3 || k > 6) ? 16'h3 : 16'h1);
    run(op, f);
    if (k < 2) begin
      cmp("carry", 16'(k == 1 || !f.carry), 16'(flags_o.carry));
      cmp("flags", 16'(f[4:1]), 16'(flags_o[4:1]));
    end
    if (k > 1 && k < 5) cmp("taken", 16'(t), 16'(taken_o));
    if (t && (k == 3 || k == 5 || k == 8)) begin
      cmp("push_hi", 16'(nx[15:8]), 16'(i_mem.m[esp - 16'h1]));
      cmp("push_lo", 16'(nx[7:0]), 16'(i_mem.m[esp - 16'h2]));
      esp = esp - 16'h2;
    end
    if (t && (k == 4 || k == 6)) begin
      nx = {i_mem.m[esp + 16'h1], i_mem.m[esp]};
      esp = esp + 16'h2;
    end
    if (t && (k == 2 || k == 3 || k > 6)) nx = a;
    if (k == 5) nx = {10'h000, op[5:3], 3'h0};
    epc = nx;
    cmp("pc", epc, pc_o);
    cmp("sp", esp, sp_o);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    step(7, -1);
    for (int k = 2; k < 6; k++) begin
      for (int i = 0; i < 8; i++) step(k, i);
    end
    repeat (6) step(6, -1);
    for (int k = 0; k < 9; k++) step(k, -1);
    repeat (300) step(int'({$random(seed)} % 9), -1);
    end_sim();
  end
endmodule
`default_nettype wire

// ==== tb/cbc_core_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module cbc_core_chk (
  input wire logic                  sys_clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  start_i,
  input wire logic [7:0]            opcode_i,
  input wire cbc_pkg::cbc_flags_t   flags_i,
  input wire cbc_pkg::cbc_mem_req_t mem_o,
  input wire logic [15:0]           pc_o,
  input wire logic [15:0]           sp_o,
  input wire cbc_pkg::cbc_flags_t   flags_o,
  input wire logic                  busy_o,
  input wire logic                  done_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic                take;
  logic                rs;
  logic [7:0]          op_q;
  logic [15:0]         sp_q;
  cbc_pkg::cbc_flags_t f_q;
  assign take = start_i && !busy_o;
  assign rs = op_q[7:6] == 2'h3 && op_q[2:0] == 3'h7;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_q <= 8'h00;
      sp_q <= 16'h0000;
      f_q <= '0;
    end else if (take) begin
      op_q <= opcode_i;
      sp_q <= sp_o;
      f_q <= flags_i;
    end
  end
  property p_inv;
    done_o && op_q == 8'h3F |-> flags_o.carry == !f_q.carry;
  endproperty
  a_inv: assert property (p_inv) else $error("carry not inverted");
  property p_keep;
    done_o && (op_q == 8'h3F || op_q == 8'h37) |-> flags_o[4:1] == f_q[4:1];
  endproperty
  a_keep: assert property (p_keep) else $error("other flag moved");
  property p_force;
    done_o && op_q == 8'h37 |-> flags_o.carry;
  endproperty
  a_force: assert property (p_force) else $error("carry not set");
  property p_clen;
    take && opcode_i == 8'h3F |-> ##[1:4] done_o;
  endproperty
  a_clen: assert property (p_clen) else $error("carry op slow");
  property p_blen;
    take && opcode_i == 8'hC3 |-> !done_o [*2] ##[1:10] done_o;
  endproperty
  a_blen: assert property (p_blen) else $error("branch length");
  property p_rpc;
    done_o && rs |-> pc_o == {10'h000, op_q[5:3], 3'h0};
  endproperty
  a_rpc: assert property (p_rpc) else $error("restart target");
  property p_rsp;
    done_o && rs |-> sp_o == sp_q - 16'h0002;
  endproperty
  a_rsp: assert property (p_rsp) else $error("restart sp");
  property p_esp;
    done_o && op_q == 8'hC9 |-> sp_o == sp_q + 16'h0002;
  endproperty
  a_esp: assert property (p_esp) else $error("exit sp");
  property p_pop;
    take && opcode_i == 8'hC9 |-> ##[1:4] (mem_o.rd && mem_o.addr == sp_q)
      ##[1:3] (mem_o.rd && mem_o.addr == sp_q + 16'h0001);
  endproperty
  a_pop: assert property (p_pop) else $error("pop order");
  property p_push;
    take && opcode_i[7:6] == 2'h3 && opcode_i[2:0] == 3'h7
      |-> ##[1:6] (mem_o.wr && mem_o.addr == sp_q - 16'h0001);
  endproperty
  a_push: assert property (p_push) else $error("push high");
  c_rst: cover property (done_o && rs);
  c_exit: cover property (done_o && op_q == 8'hC9);
  c_inv: cover property (done_o && op_q == 8'h3F);
endmodule
bind cbc_core cbc_core_chk i_chk (.sys_clk_i, .rst_n_i, .start_i,
  .opcode_i, .flags_i, .mem_o, .pc_o, .sp_o, .flags_o, .busy_o, .done_o);
`default_nettype wire

// ==== tb/cbc_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cbc_mem_model (
  // clock
  input  wire logic                  clk_i,
  // request from core, read byte back
  input  wire cbc_pkg::cbc_mem_req_t req_i,
  output logic [7:0]                 rdata_o
);
  logic [7:0] m [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) m[i] = i[7:0] ^ 8'h5A;
  end
  // read data follows the registered request; idle shows the inverse
  assign rdata_o = req_i.rd ? m[req_i.addr] : ~m[req_i.addr];
  always @(posedge clk_i) begin
    if (req_i.wr) m[req_i.addr] <= req_i.wdata;
  end
endmodule
`default_nettype wire
